// File: logic/prds_pkg.sv
// Constants, types and helpers shared by the PWM restart, dead-band and steering block.
package prds_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int TCY_NS = 40;
  localparam int TCY_CLKS = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TCY_LAST = 4'(TCY_CLKS - 1);

  // ****************************************
  // Register map and reset values
  // ****************************************
  localparam logic [7:0] OFS_RESTART = 8'h00;
  localparam logic [7:0] OFS_STEER = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_SHDN = 8'h0C;
  localparam logic [7:0] OFS_DIR = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] RST_RESTART = 8'h00;
  localparam logic [4:0] RST_STEER = 5'h01;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [3:0] RST_SHDN_STATE = 4'h0;
  localparam logic [3:0] RST_DIR = 4'hF;

  // ****************************************
  // Field positions and encodings
  // ****************************************
  localparam int RESTART_EN_BIT = 7;
  localparam int STEER_SYNC_BIT = 4;
  localparam int SHDN_STATUS_BIT = 7;
  localparam int SHDN_AC_LSB = 2;
  localparam int SHDN_BD_LSB = 0;
  localparam int MODE_CFG_LSB = 6;
  localparam int MODE_UPPER_LSB = 2;
  localparam logic [1:0] UNIT_MODE_PWM = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {WS_IDLE = 2'b01, WS_RESP = 2'b10} prds_wstate_t;
  typedef enum logic [1:0] {RS_IDLE = 2'b01, RS_DATA = 2'b10} prds_rstate_t;

  // Pins A and C share one polarity bit, B and D the other.
  function automatic logic prds_pin_level(input logic active, input logic [1:0] pol, input int idx);
    prds_pin_level = active ^ (idx[0] ? pol[0] : pol[1]);
  endfunction : prds_pin_level

endpackage : prds_pkg

// File: logic/prds_db_if.sv
// Interface between the output stage and one dead-band delay channel.
`timescale 1ns/1ps
interface prds_db_if;
  logic tick;
  logic active_in;
  logic [6:0] delay;
  logic active_out;
  modport ctl (output tick, output active_in, output delay, input active_out);
  modport chan (input tick, input active_in, input delay, output active_out);
endinterface : prds_db_if

// File: logic/prds_sync2.sv
// Two-stage synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module prds_sync2 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : prds_sync2

// File: logic/prds_deadband.sv
// One dead-band channel: delays only the inactive-to-active edge of a drive request.
`timescale 1ns/1ps
module prds_deadband import prds_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  prds_db_if.chan db
);
  logic prev;
  logic out;
  logic [6:0] cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
    end else begin
      prev <= db.active_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 7'h00;
    end else if (db.active_in && !prev) begin
      cnt <= db.delay; // RULE20
    end else if (db.tick && cnt != 7'h00) begin
      cnt <= cnt - 7'h01; // RULE5
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out <= 1'b0;
    end else if (!db.active_in) begin
      out <= 1'b0; // RULE4
    end else if (!prev) begin
      out <= (db.delay == 7'h00); // RULE19
    end else begin
      out <= (cnt == 7'h00) || (db.tick && cnt == 7'h01); // RULE20
    end
  end

  assign db.active_out = out;
endmodule : prds_deadband

// File: logic/prds_top.sv
// PWM output stage: shutdown restart, half-bridge dead band and pulse steering, on AXI4-Lite.
//
// Functional notes
// [RULE1] Automatic restart only when the restart-enable bit 7 is set.
// [RULE2] Auto restart: status stays set during condition, clears when it goes away.
// [RULE3] Without auto restart, outputs stay shut until software clears the status.
// [RULE4] Dead band delays only inactive-to-active output edges in half-bridge mode.
// [RULE5] Dead band equals the seven-bit count in instruction cycles.
// [RULE6] Steering only in single output mode: mode upper 11, config 00.
// [RULE7] Each steer enable bit routes the polarity-controlled PWM to its pin.
// [RULE8] Any combination of one to four pins may carry the PWM together.
// [RULE9] Polarity field applies to every steered pin.
// [RULE10] Shutdown forces only PWM-enabled pins; port pins are unaffected.
// [RULE11] Sync bit 0: new steering applies at the end of the write.
// [RULE12] Sync bit 1: new steering waits for the next period start.
// [RULE13] Steering register bits 7 to 5 read zero, writes ignored.
// [RULE14] Software must set at least one steer bit in single output mode.
// [RULE15] PWM reaches a pin only while its direction bit is 0.
// [RULE16] Any shutdown event sets the status until cleared or auto restart.
// [RULE17] Software writes to the status are ignored while the condition persists.
// [RULE18] After restart the output resumes only at the next period start.
// [RULE19] Zero dead-band count adds no delay.
// [RULE20] Dead band uses a counter loaded at each rising request, one step per cycle.
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module prds_top import prds_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pwm_raw,
  input wire logic period_start,
  input wire logic shutdown_request,
  input wire logic [3:0] port_data,
  output logic pwm_out_a,
  output logic pwm_out_a_oe,
  output logic pwm_out_b,
  output logic pwm_out_b_oe,
  output logic pwm_out_c,
  output logic pwm_out_c_oe,
  output logic pwm_out_d,
  output logic pwm_out_d_oe
);

  // ****************************************
  // Registers and internal state
  // ****************************************
  logic [7:0] restart_ctrl;
  logic [4:0] steer_ctrl;
  logic [7:0] mode_ctrl;
  logic [3:0] shdn_state;
  logic [3:0] pin_dir;
  logic shutdown_event_status;
  logic out_off;
  logic [3:0] steer_applied;
  logic [3:0] out_lvl;
  logic [3:0] out_oe;
  logic [3:0] tcy_cnt;
  logic tcy_tick;
  logic cond;
  prds_wstate_t wstate;
  prds_rstate_t rstate;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic wr_fire;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  logic auto_restart_enable;
  logic [6:0] deadband_delay_count;
  logic steer_sync_select;
  logic [1:0] unit_mode_upper;
  logic [1:0] output_polarity_sel;
  logic [1:0] output_config_sel;
  logic single_mode;
  logic half_mode;
  logic sw_status_wr;
  logic [3:0] drive_active;
  logic [3:0] pwm_use;
  assign auto_restart_enable = restart_ctrl[RESTART_EN_BIT];
  assign deadband_delay_count = restart_ctrl[6:0];
  assign steer_sync_select = steer_ctrl[STEER_SYNC_BIT];
  assign unit_mode_upper = mode_ctrl[MODE_UPPER_LSB +: 2];
  assign output_polarity_sel = mode_ctrl[1:0];
  assign output_config_sel = mode_ctrl[MODE_CFG_LSB +: 2];
  assign single_mode = (unit_mode_upper == UNIT_MODE_PWM) && (output_config_sel == CFG_SINGLE); // RULE6
  assign half_mode = (unit_mode_upper == UNIT_MODE_PWM) && (output_config_sel == CFG_HALF);

  // ****************************************
  // Shutdown request synchroniser
  // ****************************************
  prds_sync2 u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(shutdown_request),
    .q(cond)
  );

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data are parked separately so the master may present them in either order.
  assign wr_fire = (wstate == WS_IDLE) && aw_held && w_held;
  assign wr_ok = (aw_addr == OFS_RESTART) || (aw_addr == OFS_STEER) || (aw_addr == OFS_MODE) ||
                 (aw_addr == OFS_SHDN) || (aw_addr == OFS_DIR) || (aw_addr == OFS_STAT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= WS_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      case (wstate)
        WS_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
          end
          if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            wstate <= WS_RESP;
          end
        end
        WS_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wstate <= WS_IDLE;
          end
        end
        default: begin
          wstate <= WS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Software-written registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_ctrl <= RST_RESTART;
      steer_ctrl <= RST_STEER;
      mode_ctrl <= RST_MODE;
      shdn_state <= RST_SHDN_STATE;
      pin_dir <= RST_DIR;
    end else if (wr_fire && w_lane0) begin
      case (aw_addr)
        OFS_RESTART: restart_ctrl <= w_byte;
        OFS_STEER: steer_ctrl <= w_byte[4:0]; // RULE13
        OFS_MODE: mode_ctrl <= w_byte;
        OFS_SHDN: shdn_state <= w_byte[3:0];
        OFS_DIR: pin_dir <= w_byte[3:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Shutdown status and restart
  // ****************************************
  assign sw_status_wr = wr_fire && w_lane0 && (aw_addr == OFS_SHDN);
  // A live condition outranks any software write, so a clear in the same cycle is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shutdown_event_status <= 1'b0;
    end else if (cond) begin
      shutdown_event_status <= 1'b1; // RULE16 RULE17
    end else if (sw_status_wr && w_byte[SHDN_STATUS_BIT]) begin
      shutdown_event_status <= 1'b1; // RULE16
    end else if (auto_restart_enable) begin
      shutdown_event_status <= 1'b0; // RULE1 RULE2
    end else if (sw_status_wr) begin
      shutdown_event_status <= 1'b0; // RULE3
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_off <= 1'b0;
    end else if (cond || shutdown_event_status || (sw_status_wr && w_byte[SHDN_STATUS_BIT])) begin
      out_off <= 1'b1; // RULE3
    end else if (period_start) begin
      out_off <= 1'b0; // RULE18
    end
  end

  // ****************************************
  // Steering update
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      steer_applied <= RST_STEER[3:0];
    end else if (wr_fire && w_lane0 && aw_addr == OFS_STEER && !w_byte[STEER_SYNC_BIT]) begin
      steer_applied <= w_byte[3:0]; // RULE11
    end else if (steer_sync_select && period_start) begin
      steer_applied <= steer_ctrl[3:0]; // RULE12
    end
  end

  // ****************************************
  // Instruction-cycle tick and dead band
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tcy_cnt <= 4'h0;
    end else if (tcy_cnt == TCY_LAST) begin
      tcy_cnt <= 4'h0;
    end else begin
      tcy_cnt <= tcy_cnt + 4'h1;
    end
  end

  assign tcy_tick = (tcy_cnt == TCY_LAST);
  prds_db_if db_a_if ();
  prds_db_if db_b_if ();
  // Half bridge: A drives the modulated phase, B its complement, each with a turn-on delay taken from the same count.
  assign db_a_if.tick = tcy_tick;
  assign db_a_if.active_in = pwm_raw;
  assign db_a_if.delay = deadband_delay_count; // RULE5
  assign db_b_if.tick = tcy_tick;
  assign db_b_if.active_in = !pwm_raw;
  assign db_b_if.delay = deadband_delay_count; // RULE5
  prds_deadband u_db_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .db(db_a_if.chan)
  );
  prds_deadband u_db_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .db(db_b_if.chan)
  );

  // ****************************************
  // Output pin selection
  // ****************************************
  always_comb begin
    drive_active = 4'h0;
    pwm_use = 4'h0;
    if (single_mode) begin
      pwm_use = steer_applied; // RULE7 RULE8 RULE14
      drive_active = steer_applied & {4{pwm_raw}};
    end else if (half_mode) begin
      pwm_use = 4'h3;
      drive_active = {2'b00, db_b_if.active_out, db_a_if.active_out}; // RULE4
    end else if (unit_mode_upper == UNIT_MODE_PWM) begin
      pwm_use = 4'h1;
      drive_active = {3'b000, pwm_raw};
    end
  end

  // Shutdown codes: 00 drives low, 01 drives high, 1x releases the pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_lvl <= 4'h0;
      out_oe <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!pwm_use[i]) begin
          out_lvl[i] <= port_data[i]; // RULE10
          out_oe[i] <= !pin_dir[i];
        end else if (out_off) begin
          out_lvl[i] <= i[0] ? shdn_state[SHDN_BD_LSB] : shdn_state[SHDN_AC_LSB]; // RULE10
          out_oe[i] <= !pin_dir[i] && !(i[0] ? shdn_state[SHDN_BD_LSB + 1] : shdn_state[SHDN_AC_LSB + 1]);
        end else begin
          out_lvl[i] <= prds_pin_level(drive_active[i], output_polarity_sel, i); // RULE9
          out_oe[i] <= !pin_dir[i]; // RULE15
        end
      end
    end
  end

  assign pwm_out_a = out_lvl[0];
  assign pwm_out_b = out_lvl[1];
  assign pwm_out_c = out_lvl[2];
  assign pwm_out_d = out_lvl[3];
  assign pwm_out_a_oe = out_oe[0];
  assign pwm_out_b_oe = out_oe[1];
  assign pwm_out_c_oe = out_oe[2];
  assign pwm_out_d_oe = out_oe[3];

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFS_RESTART: rd_word[7:0] = restart_ctrl;
      OFS_STEER: rd_word[4:0] = steer_ctrl; // RULE13
      OFS_MODE: rd_word[7:0] = mode_ctrl;
      OFS_SHDN: rd_word[7:0] = {shutdown_event_status, 3'b000, shdn_state};
      OFS_DIR: rd_word[3:0] = pin_dir;
      OFS_STAT: rd_word[7:0] = {cond, out_off, 2'b00, steer_applied};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate <= RS_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      case (rstate)
        RS_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            rstate <= RS_DATA;
          end
        end
        RS_DATA: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rstate <= RS_IDLE;
          end
        end
        default: begin
          rstate <= RS_IDLE;
        end
      endcase
    end
  end

endmodule : prds_top

// File: verif/prds_properties.sv
// Concurrent checks on the register bus of the PWM output stage.
`timescale 1ns/1ps
module prds_properties import prds_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  // ****************************************
  // Bus handshakes
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write answer missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while answer pending");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h18
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  a_steer_zeros: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_STEER
    |=> s_axi_rdata[31:5] == 27'h0) else $error("steering upper bits not zero");
endmodule : prds_properties

bind prds_top prds_properties CHK (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp));

// File: verif/prds_bridge_model.sv
// Model of the power-switch drivers that hang on the four output pins.
`timescale 1ns/1ps
module prds_bridge_model (
  input wire logic [3:0] level,
  input wire logic [3:0] oe,
  output logic [3:0] gate
);
  // A released pin is pulled down, so the switch stays off rather than following a stale level.
  assign gate = level & oe;
endmodule : prds_bridge_model

// File: verif/testbench.sv
// Self-checking bench for the PWM restart, dead-band and steering stage.
`timescale 1ns/1ps
module testbench import prds_pkg::*;;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic pwm_raw = 1'h0, period_start = 1'h0, shutdown_request = 1'h0;
  logic [3:0] port_data = '0, lvl, oe, gate;
  int mismatches = 0, cmp_count = 0;

  prds_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pwm_raw(pwm_raw), .period_start(period_start), .shutdown_request(shutdown_request), .port_data(port_data),
    .pwm_out_a(lvl[0]), .pwm_out_a_oe(oe[0]), .pwm_out_b(lvl[1]), .pwm_out_b_oe(oe[1]),
    .pwm_out_c(lvl[2]), .pwm_out_c_oe(oe[2]), .pwm_out_d(lvl[3]), .pwm_out_d_oe(oe[3]));
  prds_bridge_model BRG (.level(lvl), .oe(oe), .gate(gate));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // The answer ready is raised late on purpose, so the slave has to hold its answer.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    repeat (2) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic w8(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask : w8

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e, "register read");
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
  endtask : rchk

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle

  task automatic pulse_period;
    @(posedge aclk);
    period_start <= 1'b1;
    @(posedge aclk);
    period_start <= 1'b0;
  endtask : pulse_period

  task automatic edge_lat(input logic v, output int n);
    @(posedge aclk);
    pwm_raw <= v;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (gate[0] !== v && n < 300);
  endtask : edge_lat

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    chk({28'h0, oe}, 32'h0, "drivers off after reset");
    rchk(OFS_RESTART, 32'h00);
    rchk(OFS_STEER, 32'h01);
    rchk(OFS_MODE, 32'h00);
    rchk(OFS_SHDN, 32'h00);
    rchk(OFS_DIR, 32'h0F);
    w8(OFS_RESTART, 8'hA5);
    rchk(OFS_RESTART, 32'hA5);
    w8(OFS_STEER, 8'hE5);
    rchk(OFS_STEER, 32'h05);
    wr(8'h18, 8'h55, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    rd(8'h18, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    w8(OFS_RESTART, 8'h00);
  endtask : t_regs

  task automatic t_steer;
    logic [3:0] e;
    logic [7:0] md[3] = '{8'h4C, 8'hCC, 8'h00};
    w8(OFS_DIR, 8'h00);
    for (int p = 0; p < 4; p++) begin
      w8(OFS_MODE, 8'h0C | 8'(p));
      for (int m = 1; m < 16; m++) begin
        w8(OFS_STEER, 8'(m));
        for (int v = 0; v < 2; v++) begin
          @(posedge aclk);
          pwm_raw <= v[0];
          port_data <= 4'h6 ^ {4{v[0]}};
          settle(3);
          for (int i = 0; i < 4; i++) e[i] = m[i] ? (v[0] ^ (i[0] ? p[0] : p[1])) : port_data[i];
          chk({28'h0, gate}, {28'h0, e}, "steered pins");
        end
      end
    end
    w8(OFS_MODE, 8'h0C);
    w8(OFS_DIR, 8'h01);
    settle(3);
    chk({24'h0, oe, gate}, {24'h0, 8'hEE}, "pin A kept as input");
    w8(OFS_DIR, 8'h00);
    w8(OFS_STEER, 8'h02);
    @(posedge aclk);
    port_data <= 4'h0;
    foreach (md[k]) begin
      w8(OFS_MODE, md[k]);
      settle(3);
      chk({31'h0, gate[1]}, 32'h0, "no steering outside single mode");
    end
  endtask : t_steer

  task automatic t_sync;
    logic [31:0] d;
    logic [1:0] r;
    w8(OFS_MODE, 8'h0C);
    w8(OFS_STEER, 8'h01);
    w8(OFS_STEER, 8'h02);
    settle(2);
    chk({28'h0, gate}, 32'h2, "immediate steering");
    w8(OFS_STEER, 8'h11);
    settle(4);
    chk({28'h0, gate}, 32'h2, "steering deferred");
    rd(OFS_STAT, d, r);
    chk(d & 32'h0F, 32'h2, "applied steering before period");
    pulse_period;
    settle(2);
    chk({28'h0, gate}, 32'h1, "steering after period");
  endtask : t_sync

  // Pin A is driven high while shut (pin C is a port pin here), so a shut pin differs from its PWM level.
  task automatic t_shdn(input logic [7:0] rst);
    w8(OFS_RESTART, rst);
    w8(OFS_SHDN, 8'h04);
    w8(OFS_STEER, 8'h01);
    @(posedge aclk);
    pwm_raw <= 1'b0;
    port_data <= 4'h2;
    shutdown_request <= 1'b1;
    settle(6);
    chk({28'h0, gate}, 32'h3, "pins in shutdown");
    rchk(OFS_SHDN, 32'h84);
    w8(OFS_SHDN, 8'h04);
    rchk(OFS_SHDN, 32'h84);
    @(posedge aclk);
    shutdown_request <= 1'b0;
    settle(6);
    if (rst[7]) begin
      rchk(OFS_SHDN, 32'h04);
    end else begin
      rchk(OFS_SHDN, 32'h84);
      w8(OFS_SHDN, 8'h04);
    end
    settle(4);
    chk({28'h0, gate}, 32'h3, "held until next period");
    pulse_period;
    settle(2);
    chk({28'h0, gate}, 32'h2, "output resumed");
    w8(OFS_SHDN, 8'h88);
    settle(2);
    chk({24'h0, oe, gate}, 32'hE2, "firmware event releases pin A");
    w8(OFS_SHDN, 8'h04);
    pulse_period;
  endtask : t_shdn

  task automatic t_db;
    int n;
    logic [6:0] dl[3] = '{7'h00, 7'h05, 7'h7F};
    w8(OFS_RESTART, 8'h85);
    edge_lat(1'b1, n);
    chk(32'(n), 32'd1, "single mode has no dead band");
    w8(OFS_MODE, 8'h8C);
    foreach (dl[k]) begin
      w8(OFS_RESTART, {1'b0, dl[k]});
      edge_lat(1'b0, n);
      chk(32'(n), 32'd2, "falling edge immediate");
      edge_lat(1'b1, n);
      chk(32'(n), 32'd2 + 32'(dl[k]), "rising edge delayed");
    end
  endtask : t_db

  // ****************************************
  // Clock, reset, sequence and watchdog
  // ****************************************
  initial begin
    forever #20 aclk = ~aclk;
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_steer;
    t_sync;
    t_shdn(8'h00);
    t_shdn(8'h80);
    t_db;
    summarize;
  end

  initial begin
    #2400000;
    mismatches++;
    summarize;
  end
endmodule : testbench
